/* File: hw/gtm_pkg.sv */
// Functional notes
// - Config value 4 gives two 16-bit halves
// - 16-bit down-counter, optional 8-bit prescale
// - Run counts down, reloads after zero
// - One-shot stops and clears run; periodic continues
// - Zero sets sticky time-out flag, masked interrupt
// - Time-out pulses ADC trigger when enabled
// - Interval load write adopted next cycle
// - Freeze bit holds count during debug halt
// - Prescale P gives P+1 clocks per count
// - Prescaler bypassed outside one-shot and periodic
// - Capture bit clear: edge count, event select
// - Edges decrement until match, set match flag
// - Match reloads, clears run, ignores edges
// - Capture bit set: free-running edge timer
// - Selected edge captures count, sets capture flag
// - Edge timer keeps running, reloads at zero
// - Captured count held until next edge
// - PWM selected by alternate, capture, mode fields
// - PWM repeats until stopped, no flags
// - PWM high at load, low at match
// - Reset: counters, loads all-ones, prescale zero
package gtm_pkg;
   localparam int CNT_W = 16;
   localparam int PRE_W = 8;
   localparam int NHALF = 2;
   // Byte offsets; per-half registers step by one word
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_MODE_A = 8'h04;
   localparam logic [7:0] OFF_MODE_B = 8'h08;
   localparam logic [7:0] OFF_CTL = 8'h0C;
   localparam logic [7:0] OFF_IMR = 8'h18;
   localparam logic [7:0] OFF_RIS = 8'h1C;
   localparam logic [7:0] OFF_MIS = 8'h20;
   localparam logic [7:0] OFF_ICR = 8'h24;
   localparam logic [7:0] OFF_ILR_A = 8'h28;
   localparam logic [7:0] OFF_ILR_B = 8'h2C;
   localparam logic [7:0] OFF_MATCH_A = 8'h30;
   localparam logic [7:0] OFF_MATCH_B = 8'h34;
   localparam logic [7:0] OFF_PRE_A = 8'h38;
   localparam logic [7:0] OFF_PRE_B = 8'h3C;
   localparam logic [7:0] OFF_VAL_A = 8'h48;
   localparam logic [7:0] OFF_VAL_B = 8'h4C;
   localparam logic [7:0] HALF_STEP = 8'h04;
   // Module configuration
   localparam logic [2:0] CFG_16BIT = 3'h4;
   localparam logic [2:0] CFG_RST = 3'h0;
   // Half mode register fields
   localparam int MODE_CM_LSB = 0;
   localparam int MODE_CMR_BIT = 2;
   localparam int MODE_AMS_BIT = 3;
   localparam logic [1:0] CM_ONESHOT = 2'h1;
   localparam logic [1:0] CM_PERIODIC = 2'h2;
   localparam logic [1:0] CM_CAPTURE = 2'h3;
   // Control register fields, half B sits one stride above half A
   localparam int CTL_STRIDE = 8;
   localparam int CTL_RUN = 0;
   localparam int CTL_FRZ = 1;
   localparam int CTL_EVT_LSB = 2;
   localparam int CTL_OTE = 5;
   localparam int CTL_INV = 6;
   localparam logic [15:0] CTL_VALID = 16'h6F6F;
   localparam logic [1:0] EVT_RISE = 2'h0;
   localparam logic [1:0] EVT_FALL = 2'h1;
   localparam logic [1:0] EVT_BOTH = 2'h3;
   // Status fields, same stride as control
   localparam int ST_STRIDE = 8;
   localparam int ST_TO = 0;
   localparam int ST_MATCH = 1;
   localparam int ST_CAPT = 2;
   localparam logic [15:0] ST_VALID = 16'h0707;
   // Reset values
   localparam logic [15:0] CNT_RST = 16'hFFFF;
   localparam logic [15:0] ILR_RST = 16'hFFFF;
   localparam logic [7:0] PRE_RST = 8'h00;
endpackage : gtm_pkg

/* File: hw/gtm_timer.sv */
// Implementation choices: the address map and the AHB-Lite register port.
module gtm_timer
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] ccp_in,
   input wire logic debug_halt,
   output logic [1:0] pwm_out,
   output logic [1:0] adc_trigger,
   output logic irq
);

   logic [2:0] module_config_reg;
   logic [15:0] timer_control_reg, next_ctl;
   logic [15:0] interrupt_mask_reg;
   logic [15:0] raw_status_reg, masked_status_reg;
   logic [15:0] st_set, st_clr;
   logic [1:0] count_mode_field [gtm_pkg::NHALF];
   logic capture_mode_bit [gtm_pkg::NHALF];
   logic alternate_mode_bit [gtm_pkg::NHALF];
   logic [15:0] interval_load_reg [gtm_pkg::NHALF];
   logic [15:0] match_value_reg [gtm_pkg::NHALF];
   logic [7:0] prescale_reg [gtm_pkg::NHALF];
   logic [15:0] timer_value_reg [gtm_pkg::NHALF];
   logic [15:0] cnt [gtm_pkg::NHALF];
   logic [7:0] pre_cnt [gtm_pkg::NHALF];
   logic ccp_prev [gtm_pkg::NHALF], pwm_lvl [gtm_pkg::NHALF];
   wire [gtm_pkg::NHALF-1:0] to_evt, match_evt, cap_evt, run_clr;
   logic addr_ok, wr_pend, split16;
   logic [7:0] wr_addr;
   logic [31:0] rd_mux;
   logic wr_cfg, wr_ctl, wr_imr, wr_icr;

   // Address phase qualifier; the slave never stretches a transfer
   assign addr_ok = hsel && htrans[1] && hready;
   assign split16 = (module_config_reg == gtm_pkg::CFG_16BIT);

   // Latch the address phase so the write lands with its data phase
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite;
         if (addr_ok)
            wr_addr <= haddr[7:0];
      end
   end

   assign wr_cfg = wr_pend && (wr_addr == gtm_pkg::OFF_CFG);
   assign wr_ctl = wr_pend && (wr_addr == gtm_pkg::OFF_CTL);
   assign wr_imr = wr_pend && (wr_addr == gtm_pkg::OFF_IMR);
   assign wr_icr = wr_pend && (wr_addr == gtm_pkg::OFF_ICR);

   // Read decode; unmapped offsets read as zero
   always_comb
   begin
      rd_mux = 32'h00000000;
      unique case (haddr[7:0])
         gtm_pkg::OFF_CFG: rd_mux[2:0] = module_config_reg;
         gtm_pkg::OFF_MODE_A:
            rd_mux[3:0] = {alternate_mode_bit[0], capture_mode_bit[0],
                           count_mode_field[0]};
         gtm_pkg::OFF_MODE_B:
            rd_mux[3:0] = {alternate_mode_bit[1], capture_mode_bit[1],
                           count_mode_field[1]};
         gtm_pkg::OFF_CTL: rd_mux[15:0] = timer_control_reg;
         gtm_pkg::OFF_IMR: rd_mux[15:0] = interrupt_mask_reg;
         gtm_pkg::OFF_RIS: rd_mux[15:0] = raw_status_reg;
         gtm_pkg::OFF_MIS: rd_mux[15:0] = masked_status_reg;
         gtm_pkg::OFF_ILR_A: rd_mux[15:0] = interval_load_reg[0];
         gtm_pkg::OFF_ILR_B: rd_mux[15:0] = interval_load_reg[1];
         gtm_pkg::OFF_MATCH_A: rd_mux[15:0] = match_value_reg[0];
         gtm_pkg::OFF_MATCH_B: rd_mux[15:0] = match_value_reg[1];
         gtm_pkg::OFF_PRE_A: rd_mux[7:0] = prescale_reg[0];
         gtm_pkg::OFF_PRE_B: rd_mux[7:0] = prescale_reg[1];
         gtm_pkg::OFF_VAL_A: rd_mux[15:0] = timer_value_reg[0];
         gtm_pkg::OFF_VAL_B: rd_mux[15:0] = timer_value_reg[1];
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Read data is registered in the address phase, valid in data phase
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         if (addr_ok && !hwrite)
            hrdata <= rd_mux;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Global configuration and mask
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         module_config_reg <= gtm_pkg::CFG_RST;
         interrupt_mask_reg <= 16'h0000;
      end
      else
      begin
         if (wr_cfg)
            module_config_reg <= hwdata[2:0];
         if (wr_imr)
            interrupt_mask_reg <= hwdata[15:0] & gtm_pkg::ST_VALID;
      end
   end

   // Software write wins over a hardware stop in the same cycle
   always_comb
   begin
      next_ctl = timer_control_reg;
      if (wr_ctl)
         next_ctl = hwdata[15:0] & gtm_pkg::CTL_VALID;
      else
         for (int i = 0; i < gtm_pkg::NHALF; i++)
            if (run_clr[i])
               next_ctl[i*gtm_pkg::CTL_STRIDE+gtm_pkg::CTL_RUN] = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         timer_control_reg <= 16'h0000;
      else
         timer_control_reg <= next_ctl;
   end

   // Gather events of both halves into status positions
   always_comb
   begin
      st_set = 16'h0000;
      for (int i = 0; i < gtm_pkg::NHALF; i++)
      begin
         st_set[i*gtm_pkg::ST_STRIDE+gtm_pkg::ST_TO] = to_evt[i];
         st_set[i*gtm_pkg::ST_STRIDE+gtm_pkg::ST_MATCH] = match_evt[i];
         st_set[i*gtm_pkg::ST_STRIDE+gtm_pkg::ST_CAPT] = cap_evt[i];
      end
   end

   assign st_clr = wr_icr ? (hwdata[15:0] & gtm_pkg::ST_VALID) : 16'h0000;
   assign masked_status_reg = raw_status_reg & interrupt_mask_reg;

   // Sticky flags: a new event beats a clear arriving with it
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         raw_status_reg <= 16'h0000;
      else
         raw_status_reg <= (raw_status_reg & ~st_clr) | st_set;
   end

   // Interrupt line lags the masked flags by one clock
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= |masked_status_reg;
   end

   for (genvar h = 0; h < gtm_pkg::NHALF; h++)
   begin : g_half
      localparam logic [7:0] A_MODE =
         8'(gtm_pkg::OFF_MODE_A + 8'(h) * gtm_pkg::HALF_STEP);
      localparam logic [7:0] A_ILR =
         8'(gtm_pkg::OFF_ILR_A + 8'(h) * gtm_pkg::HALF_STEP);
      localparam logic [7:0] A_MATCH =
         8'(gtm_pkg::OFF_MATCH_A + 8'(h) * gtm_pkg::HALF_STEP);
      localparam logic [7:0] A_PRE =
         8'(gtm_pkg::OFF_PRE_A + 8'(h) * gtm_pkg::HALF_STEP);
      localparam int CB = h * gtm_pkg::CTL_STRIDE;
      logic wr_mode, wr_ilr, wr_match, wr_pre;
      logic run, active, frozen;
      logic [1:0] evt;
      logic rise, fall, sel_edge;
      logic is_per, is_cnt, is_time, is_pwm;
      logic at_zero, next_lvl;
      logic [15:0] dec;

      assign wr_mode = wr_pend && (wr_addr == A_MODE);
      assign wr_ilr = wr_pend && (wr_addr == A_ILR);
      assign wr_match = wr_pend && (wr_addr == A_MATCH);
      assign wr_pre = wr_pend && (wr_addr == A_PRE);
      assign run = timer_control_reg[CB+gtm_pkg::CTL_RUN];
      assign evt = timer_control_reg[CB+gtm_pkg::CTL_EVT_LSB +: 2];
      assign active = split16 && run;
      // Stall only while the debugger holds the core
      assign frozen = timer_control_reg[CB+gtm_pkg::CTL_FRZ] &&
                      debug_halt;

      // Mode decode
      assign is_per = !alternate_mode_bit[h] && !capture_mode_bit[h] &&
                      ((count_mode_field[h] == gtm_pkg::CM_ONESHOT) ||
                       (count_mode_field[h] == gtm_pkg::CM_PERIODIC));
      assign is_cnt = !alternate_mode_bit[h] && !capture_mode_bit[h] &&
                      (count_mode_field[h] == gtm_pkg::CM_CAPTURE);
      assign is_time = !alternate_mode_bit[h] && capture_mode_bit[h] &&
                       (count_mode_field[h] == gtm_pkg::CM_CAPTURE);
      assign is_pwm = alternate_mode_bit[h] && !capture_mode_bit[h] &&
                      (count_mode_field[h] == gtm_pkg::CM_PERIODIC);

      assign at_zero = (cnt[h] == 16'h0000);
      assign dec = cnt[h] - 16'h0001;

      // Pin is synchronous; one stage of history finds the edges
      assign rise = ccp_in[h] && !ccp_prev[h];
      assign fall = !ccp_in[h] && ccp_prev[h];

      // Both-edge select falls back to rising edges for edge timing
      always_comb
      begin
         unique case (evt)
            gtm_pkg::EVT_FALL: sel_edge = fall;
            gtm_pkg::EVT_BOTH: sel_edge = is_time ? rise : (rise || fall);
            default: sel_edge = rise;
         endcase
      end

      assign to_evt[h] = active && !frozen && is_per && at_zero;
      assign match_evt[h] = active && !frozen && is_cnt && sel_edge &&
                            (dec == match_value_reg[h]);
      assign cap_evt[h] = active && !frozen && is_time && sel_edge;
      assign run_clr[h] = match_evt[h] || (to_evt[h] &&
                          (count_mode_field[h] == gtm_pkg::CM_ONESHOT));

      // Software-written per-half registers
      always_ff @(posedge sys_clk or negedge rstn)
      begin
         if (!rstn)
         begin
            count_mode_field[h] <= 2'h0;
            capture_mode_bit[h] <= 1'b0;
            alternate_mode_bit[h] <= 1'b0;
            interval_load_reg[h] <= gtm_pkg::ILR_RST;
            match_value_reg[h] <= 16'h0000;
            prescale_reg[h] <= gtm_pkg::PRE_RST;
         end
         else
         begin
            if (wr_mode)
            begin
               count_mode_field[h] <= hwdata[gtm_pkg::MODE_CM_LSB +: 2];
               capture_mode_bit[h] <= hwdata[gtm_pkg::MODE_CMR_BIT];
               alternate_mode_bit[h] <= hwdata[gtm_pkg::MODE_AMS_BIT];
            end
            if (wr_ilr)
               interval_load_reg[h] <= hwdata[15:0];
            if (wr_match)
               match_value_reg[h] <= hwdata[15:0];
            if (wr_pre)
               prescale_reg[h] <= hwdata[7:0];
         end
      end

      // Counter and prescaler
      always_ff @(posedge sys_clk or negedge rstn)
      begin
         if (!rstn)
         begin
            cnt[h] <= gtm_pkg::CNT_RST;
            pre_cnt[h] <= gtm_pkg::PRE_RST;
         end
         else if (wr_ilr)
         begin
            cnt[h] <= hwdata[15:0];
            pre_cnt[h] <= prescale_reg[h];
         end
         else if (active && !frozen)
         begin
            if (is_per)
            begin
               if (at_zero)
               begin
                  cnt[h] <= interval_load_reg[h];
                  pre_cnt[h] <= prescale_reg[h];
               end
               else if (pre_cnt[h] == 8'h00)
               begin
                  cnt[h] <= dec;
                  pre_cnt[h] <= prescale_reg[h];
               end
               else
                  pre_cnt[h] <= pre_cnt[h] - 8'h01;
            end
            else if (is_cnt)
            begin
               // Prescaler untouched outside one-shot and periodic
               if (sel_edge)
                  cnt[h] <= (dec == match_value_reg[h]) ?
                            interval_load_reg[h] : dec;
            end
            else if (is_time || is_pwm)
               cnt[h] <= at_zero ? interval_load_reg[h] : dec;
         end
      end

      // In edge-time mode the capture register holds until the next selected edge; other modes copy the count
      always_ff @(posedge sys_clk or negedge rstn)
      begin
         if (!rstn)
            timer_value_reg[h] <= gtm_pkg::CNT_RST;
         else if (cap_evt[h])
            timer_value_reg[h] <= cnt[h];
         else if (!is_time)
            timer_value_reg[h] <= cnt[h];
      end

      // PWM level: set at start value, cleared at match
      always_comb
      begin
         next_lvl = pwm_lvl[h];
         if (active && is_pwm)
         begin
            if (cnt[h] == interval_load_reg[h])
               next_lvl = 1'b1;
            else if (cnt[h] == match_value_reg[h])
               next_lvl = 1'b0;
         end
      end

      // Edge history, PWM pin and ADC trigger, all registered
      always_ff @(posedge sys_clk or negedge rstn)
      begin
         if (!rstn)
         begin
            ccp_prev[h] <= 1'b0;
            pwm_lvl[h] <= 1'b0;
            pwm_out[h] <= 1'b0;
            adc_trigger[h] <= 1'b0;
         end
         else
         begin
            ccp_prev[h] <= ccp_in[h];
            pwm_lvl[h] <= next_lvl;
            pwm_out[h] <= next_lvl ^
                          timer_control_reg[CB+gtm_pkg::CTL_INV];
            adc_trigger[h] <= to_evt[h] &&
                              timer_control_reg[CB+gtm_pkg::CTL_OTE];
         end
      end
   end

endmodule : gtm_timer

/* File: testbench/gtm_timer_assertions.sv */
module gtm_timer_chk
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [1:0] adc_trigger,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ctl_wr;
   logic [31:0] ctl_sw;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   // Software view of control; hardware run clears are not mirrored
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl_wr <= 1'b0;
         ctl_sw <= 32'h0;
      end
      else
      begin
         ctl_wr <= hsel & htrans[1] & hready & hwrite
            & (haddr[7:0] == gtm_pkg::OFF_CTL);
         if (ctl_wr)
            ctl_sw <= hwdata;
      end
   end
   // Read address phase accepted at this edge
   sequence rd_taken(logic [7:0] a);
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
   endsequence
   chk_ready_high:
   assert property (hreadyout == 1'b1)
      else $error("hreadyout dropped");
   chk_resp_okay:
   assert property (hresp == 1'b0)
      else $error("hresp not okay");
   chk_reset_quiet:
   assert property ($rose(rstn) |-> !irq && adc_trigger == 2'h0
      && hrdata == 32'h0)
      else $error("outputs busy after reset");
   chk_unmapped_zero:
   assert property (rd_taken(8'h40) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_clear_reads_zero:
   assert property (rd_taken(gtm_pkg::OFF_ICR) |=> hrdata == 32'h0)
      else $error("clear register read not zero");
   chk_irq_mis:
   assert property (rd_taken(gtm_pkg::OFF_MIS)
      |=> irq == |(hrdata[15:0] & gtm_pkg::ST_VALID))
      else $error("irq disagrees with masked status");
   chk_trig_enable:
   assert property (adc_trigger[0] |-> $past(ctl_sw[gtm_pkg::CTL_OTE])
      || $past(ctl_sw[gtm_pkg::CTL_OTE], 2))
      else $error("trigger without enable");
   chk_trig_pulse:
   assert property (adc_trigger[0] |=> !adc_trigger[0])
      else $error("trigger longer than one cycle");
   chk_rdata_stands:
   assert property (!$past(hsel && htrans[1] && hready && !hwrite)
      |-> $stable(hrdata))
      else $error("read data changed without read");
endmodule : gtm_timer_chk

/* File: testbench/gtm_edge_src.sv */
module gtm_edge_src
(
   input wire logic sys_clk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'b0;
   // One rise and one fall; each level held three clocks
   task pulse();
      repeat (3) @(posedge sys_clk);
      pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : pulse
endmodule : gtm_edge_src

/* File: testbench/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic debug_halt = 1'b0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic pin_a;
   logic [31:0] hrdata;
   logic [31:0] v1;
   logic [31:0] v2;
   logic [1:0] ccp_in;
   logic [1:0] pwm_out;
   logic [1:0] adc_trigger;
   int err_total = 0;
   int n_checks = 0;
   // Single slave: its ready is the bus ready; half B pin unused
   assign hready = hreadyout;
   assign ccp_in = {1'b0, pin_a};
   always #4 sys_clk = ~sys_clk;
   gtm_timer i_gtm_timer (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ccp_in(ccp_in),
      .debug_halt(debug_halt), .pwm_out(pwm_out),
      .adc_trigger(adc_trigger), .irq(irq));
   gtm_edge_src src (.sys_clk(sys_clk), .pin(pin_a));
   task stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Bounded wait for the slave's ready; a hang ends the run
   task wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         err_total++;
         stop_test();
      end
   endtask : wait_rdy
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d);
      xfer(1'b0, a, 32'h0);
      d = hrdata;
   endtask : rd
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask : rdc
   // Edges from now until the next trigger pulse of half h
   task wait_adc(input int h, output int n);
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (adc_trigger[h] !== 1'b1 && n < 600);
      if (adc_trigger[h] !== 1'b1)
      begin
         err_total++;
         stop_test();
      end
   endtask : wait_adc
   // First two intervals are skipped: they may straddle a register write
   task period(input int h, input int e, input string nm);
      int n;
      wait_adc(h, n);
      wait_adc(h, n);
      wait_adc(h, n);
      chk(nm, 32'(e), 32'(n));
   endtask : period
   task quiet(input int c);
      int k;
      k = 0;
      repeat (c)
      begin
         @(posedge sys_clk);
         if (adc_trigger[0] !== 1'b0)
            k++;
      end
      chk("adc quiet", 32'h0, 32'(k));
   endtask : quiet
   task hi_cnt(input int e, input string nm);
      int k;
      k = 0;
      repeat (20) @(posedge sys_clk);
      repeat (10)
      begin
         @(posedge sys_clk);
         if (pwm_out[0] === 1'b1)
            k++;
      end
      chk(nm, 32'(e), 32'(k));
   endtask : hi_cnt
   task t_reset();
      rdc("ilr a", gtm_pkg::OFF_ILR_A, 32'h0000FFFF);
      rdc("ilr b", gtm_pkg::OFF_ILR_B, 32'h0000FFFF);
      rdc("pre a", gtm_pkg::OFF_PRE_A, 32'h0);
      rdc("pre b", gtm_pkg::OFF_PRE_B, 32'h0);
      rdc("val a", gtm_pkg::OFF_VAL_A, 32'h0000FFFF);
      rdc("val b", gtm_pkg::OFF_VAL_B, 32'h0000FFFF);
      rdc("unmapped", 8'h40, 32'h0);
      rdc("icr", gtm_pkg::OFF_ICR, 32'h0);
      rdc("mis", gtm_pkg::OFF_MIS, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_oneshot();
      int n;
      wr(gtm_pkg::OFF_CFG, 32'h4);
      wr(gtm_pkg::OFF_MODE_A, 32'h1);
      wr(gtm_pkg::OFF_PRE_A, 32'h2);
      wr(gtm_pkg::OFF_ILR_A, 32'h3);
      wr(gtm_pkg::OFF_IMR, 32'h1);
      wr(gtm_pkg::OFF_CTL, 32'h21);
      wait_adc(0, n);
      chk("oneshot time", 32'h1, {31'h0, n >= 9 && n <= 15});
      repeat (2) @(posedge sys_clk);
      chk("irq set", 32'h1, {31'h0, irq});
      rdc("ris timeout", gtm_pkg::OFF_RIS, 32'h1);
      rdc("run cleared", gtm_pkg::OFF_CTL, 32'h20);
      quiet(40);
      rdc("mis timeout", gtm_pkg::OFF_MIS, 32'h1);
      wr(gtm_pkg::OFF_ICR, 32'h1);
      rdc("ris cleared", gtm_pkg::OFF_RIS, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk("irq clear", 32'h0, {31'h0, irq});
      $display("test oneshot done");
   endtask : t_oneshot
   task t_periodic();
      wr(gtm_pkg::OFF_MODE_A, 32'h2);
      wr(gtm_pkg::OFF_PRE_A, 32'h0);
      wr(gtm_pkg::OFF_ILR_A, 32'h4);
      wr(gtm_pkg::OFF_CTL, 32'h21);
      period(0, 5, "period pre0");
      wr(gtm_pkg::OFF_ILR_A, 32'h7);
      period(0, 8, "new load");
      wr(gtm_pkg::OFF_PRE_A, 32'h1);
      period(0, 15, "period pre1");
      wr(gtm_pkg::OFF_PRE_A, 32'hFF);
      wr(gtm_pkg::OFF_ILR_A, 32'h1);
      period(0, 257, "period pre255");
      wr(gtm_pkg::OFF_PRE_A, 32'h0);
      wr(gtm_pkg::OFF_ILR_A, 32'h7);
      wr(gtm_pkg::OFF_CTL, 32'h1);
      wr(gtm_pkg::OFF_ICR, 32'h1);
      quiet(30);
      rdc("timeout no trig", gtm_pkg::OFF_RIS, 32'h1);
      debug_halt <= 1'b1;
      wr(gtm_pkg::OFF_CTL, 32'h23);
      quiet(40);
      debug_halt <= 1'b0;
      period(0, 8, "resume");
      debug_halt <= 1'b1;
      wr(gtm_pkg::OFF_CTL, 32'h21);
      period(0, 8, "no freeze");
      debug_halt <= 1'b0;
      wr(gtm_pkg::OFF_MODE_B, 32'h2);
      wr(gtm_pkg::OFF_ILR_B, 32'h4);
      wr(gtm_pkg::OFF_CTL, 32'h2100);
      period(1, 5, "half b");
      quiet(20);
      wr(gtm_pkg::OFF_CTL, 32'h0);
      $display("test periodic done");
   endtask : t_periodic
   task t_count();
      int i;
      logic [31:0] e;
      wr(gtm_pkg::OFF_MODE_A, 32'h3);
      // A live prescale must not slow edge counting, timing or PWM
      wr(gtm_pkg::OFF_PRE_A, 32'h3);
      // Rising, falling, both: one pulse gives one or two edges
      for (i = 0; i < 3; i++)
      begin
         e = (i == 2) ? 32'hC : 32'(i) << 2;
         wr(gtm_pkg::OFF_ICR, 32'h707);
         wr(gtm_pkg::OFF_ILR_A, 32'hA);
         wr(gtm_pkg::OFF_MATCH_A, 32'h8);
         wr(gtm_pkg::OFF_CTL, e | 32'h1);
         src.pulse();
         rdc("one pulse", gtm_pkg::OFF_RIS, (i == 2) ? 32'h2 : 32'h0);
         src.pulse();
         rdc("match", gtm_pkg::OFF_RIS, 32'h2);
         rdc("run off", gtm_pkg::OFF_CTL, e);
         src.pulse();
         rdc("reloaded", gtm_pkg::OFF_VAL_A, 32'hA);
      end
      $display("test count done");
   endtask : t_count
   task t_time();
      wr(gtm_pkg::OFF_ICR, 32'h707);
      wr(gtm_pkg::OFF_MODE_A, 32'h7);
      wr(gtm_pkg::OFF_ILR_A, 32'hFFFF);
      wr(gtm_pkg::OFF_CTL, 32'h1);
      src.pulse();
      rd(gtm_pkg::OFF_VAL_A, v1);
      chk("capt hi", 32'h1, {31'h0, v1 > 32'hFF00 && v1 < 32'hFFFF});
      rdc("capt flag", gtm_pkg::OFF_RIS, 32'h4);
      rdc("capt held", gtm_pkg::OFF_VAL_A, v1);
      src.pulse();
      rd(gtm_pkg::OFF_VAL_A, v2);
      chk("capt newer", 32'h1, {31'h0, v2 < v1});
      wr(gtm_pkg::OFF_ILR_A, 32'h30);
      repeat (100) @(posedge sys_clk);
      src.pulse();
      rd(gtm_pkg::OFF_VAL_A, v1);
      chk("capt reload", 32'h1, {31'h0, v1 <= 32'h30});
      wr(gtm_pkg::OFF_CTL, 32'h0);
      $display("test time done");
   endtask : t_time
   task t_pwm();
      wr(gtm_pkg::OFF_ICR, 32'h707);
      wr(gtm_pkg::OFF_MODE_A, 32'hA);
      wr(gtm_pkg::OFF_ILR_A, 32'h9);
      wr(gtm_pkg::OFF_MATCH_A, 32'h3);
      wr(gtm_pkg::OFF_CTL, 32'h1);
      hi_cnt(6, "pwm high");
      wr(gtm_pkg::OFF_CTL, 32'h41);
      hi_cnt(4, "pwm inverted");
      rdc("pwm no flags", gtm_pkg::OFF_RIS, 32'h0);
      wr(gtm_pkg::OFF_CTL, 32'h0);
      $display("test pwm done");
   endtask : t_pwm
   // Main sequence
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_oneshot();
      t_periodic();
      t_count();
      t_time();
      t_pwm();
      stop_test();
   end
endmodule : tb_top
bind gtm_timer gtm_timer_chk i_chk (.sys_clk(sys_clk), .rstn(rstn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .adc_trigger(adc_trigger),
   .irq(irq));
